// file: tb/protocol_timer_mode_prescaler_test.sv
// Self-checking bench for the protocol timer.
// Assumes the bench is the only APB master and drives protocol pulses on pclk.
`timescale 1ns/1ps
module protocol_timer_mode_prescaler_test;
	logic                    pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, st, irq;
	logic [9:0]              paddr = '0;
	logic [31:0]             pwdata = '0, prdata, rv;
	logic                    pready, pslverr;
	ptm_pkg::ptm_proto_t     proto = '0;
	ptm_pkg::ptm_gate_pins_t pins = '0;
	int                      n_fail = 0, compares = 0, cyc = 0, n;
	always #2.5 pclk = ~pclk;
	ptm_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.proto, .gate_pins(pins), .timer_active_status(st), .irq);
	////////////////////////////////////////////////////////////////////////////
	task chk(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task finish_test;
		if (n_fail == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// Waits on pready; only the cycle ceiling ends a hung access
	task bus(logic w, logic [7:0] idx, logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : bus
	task pulse(logic tx);
		proto <= tx ? 2'b10 : 2'b01;
		@(posedge pclk);
		proto <= '0;
		repeat (2) @(posedge pclk);
	endtask : pulse
	task wait_st(int lim);
		n = 0;
		while (st === 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_st
	////////////////////////////////////////////////////////////////////////////
	task t_regs;
		bus(0, 8'h2A, 0);
		chk("mode reset", rv, 32'h0);
		bus(0, 8'h2B, 0);
		chk("presc reset", rv, 32'h0);
		bus(1, 8'h2A, 32'h5F);
		bus(0, 8'h2A, 0);
		chk("mode rw", rv, 32'h5F);
		bus(0, 8'h10, 0);
		chk("unmapped", 32'(err), 32'h1);
	endtask : t_regs
	task t_proto;
		bus(1, 8'h2A, 32'h80);
		bus(1, 8'h40, 1000);
		pulse(1);
		chk("auto start", 32'(st), 32'h1);
		pulse(0);
		chk("first bit stop", 32'(st), 32'h0);
		bus(1, 8'h42, 4);
		pulse(1);
		pulse(0);
		chk("multi keeps", 32'(st), 32'h1);
		bus(1, 8'h42, 6);
		chk("stop now", 32'(st), 32'h0);
		bus(1, 8'h42, 0);
		bus(1, 8'h2A, 0);
		pulse(1);
		chk("no auto start", 32'(st), 32'h0);
		bus(1, 8'h42, 1);
		pulse(0);
		chk("no auto stop", 32'(st), 32'h1);
		bus(1, 8'h42, 2);
	endtask : t_proto
	// Prescaler 0x100 takes about 7552 cycles a tick; a swapped nibble gives 472
	task t_expiry;
		bus(1, 8'h2A, 1);
		bus(1, 8'h40, 1);
		bus(1, 8'h45, 1);
		bus(1, 8'h42, 1);
		wait_st(9000);
		chk("tick period", 32'(n >= 7450 && n <= 7650), 32'h1);
		@(posedge pclk);
		chk("expiry irq", 32'(irq), 32'h1);
		bus(0, 8'h41, 0);
		chk("count zero", rv, 32'h0);
		bus(1, 8'h45, 0);
		chk("masked", 32'(irq), 32'h0);
		bus(1, 8'h44, 1);
	endtask : t_expiry
	// Low byte 4 gives three ticks in about 340 cycles; an ignored low byte gives about 90
	task t_reload;
		bus(1, 8'h2A, 32'h10);
		bus(1, 8'h2B, 4);
		bus(1, 8'h40, 3);
		bus(1, 8'h45, 2);
		bus(1, 8'h42, 1);
		n = 0;
		while (irq !== 1'b1 && n < 500) begin
			@(posedge pclk);
			n++;
		end
		chk("wrap irq", 32'(irq), 32'h1);
		chk("wrap period", 32'(n >= 300 && n <= 380), 32'h1);
		chk("still running", 32'(st), 32'h1);
		bus(1, 8'h40, 200);
		bus(0, 8'h41, 0);
		chk("old reload", 32'(rv <= 3), 32'h1);
		bus(1, 8'h42, 2);
		bus(1, 8'h42, 1);
		bus(0, 8'h41, 0);
		chk("new reload", 32'(rv >= 199 && rv <= 200), 32'h1);
		bus(1, 8'h42, 2);
		bus(1, 8'h44, 3);
		chk("irq cleared", 32'(irq), 32'h0);
	endtask : t_reload
	task t_gate;
		bus(1, 8'h2B, 0);
		for (int g = 1; g < 4; g++) begin
			bus(1, 8'h2A, 32'(g << 5));
			bus(1, 8'h40, 100);
			pins <= ~(3'b1 << (3 - g));
			bus(1, 8'h42, 1);
			repeat (100) @(posedge pclk);
			chk("gated status", 32'(st), 32'h1);
			bus(0, 8'h41, 0);
			chk("gate closed", rv, 32'd100);
			pins <= 3'b1 << (3 - g);
			repeat (100) @(posedge pclk);
			bus(0, 8'h41, 0);
			chk("gate open", 32'(rv < 100), 32'h1);
			bus(1, 8'h42, 2);
			pins <= '0;
		end
	endtask : t_gate
	////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs();
		t_proto();
		t_expiry();
		t_reload();
		t_gate();
		finish_test();
	end
endmodule : protocol_timer_mode_prescaler_test

// file: tb/ptm_timer_assertions.sv
// Port checker for the protocol timer.
// Assumes bind to ptm_timer; mode and control bits are shadowed from APB writes.
`timescale 1ns/1ps
module ptm_checker (
	// Clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// APB
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [9:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	// Events and status
	input wire ptm_pkg::ptm_proto_t     proto,
	input wire ptm_pkg::ptm_gate_pins_t gate_pins,
	input wire logic                    timer_active_status,
	input wire logic                    irq
);
	logic acc, wr_ctrl, auto_q, multi_q;
	assign acc = psel && penable && pready && pwrite;
	assign wr_ctrl = acc && paddr[9:2] == 8'h42;
	// Shadows need only the write path; reads cannot change them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_q <= 1'b0;
			multi_q <= 1'b0;
		end else begin
			if (acc && paddr[9:2] == 8'h2A) auto_q <= pwdata[7];
			if (wr_ctrl) multi_q <= pwdata[2];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pready_once: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
	a_err_paired: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
	a_auto_start: assert property (proto.tx_end && !proto.rx_first_bit && auto_q && !wr_ctrl
		|=> timer_active_status) else $error("no start at end of send");
	a_rx_stop: assert property (proto.rx_first_bit && auto_q && !multi_q |=> !timer_active_status)
		else $error("no stop on first bit");
	a_multi_keep: assert property (proto.rx_first_bit && multi_q && timer_active_status
		&& !wr_ctrl |=> timer_active_status) else $error("stopped by received data");
	a_stop_now: assert property (wr_ctrl && pwdata[1] |=> !timer_active_status) else $error("stop ignored");
	a_start_cause: assert property ($rose(timer_active_status) |-> $past(proto.tx_end && auto_q
		|| wr_ctrl && pwdata[0])) else $error("start without cause");
	c_auto: cover property (proto.tx_end && auto_q ##1 timer_active_status);
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
endmodule : ptm_checker
bind ptm_timer ptm_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .proto, .gate_pins, .timer_active_status, .irq);

// file: verilog/ptm_params.svh
// Constants for the protocol timer: register indices, field positions, resets, timing.
// Assumes inclusion by bare name from the timer's design file.
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH

// Register indices; byte address is four times the index
`define PTM_IDX_MODE       8'h2A
`define PTM_IDX_PRESC      8'h2B
`define PTM_IDX_RELOAD     8'h40
`define PTM_IDX_COUNT      8'h41
`define PTM_IDX_CTRL       8'h42
`define PTM_IDX_STATUS     8'h43
`define PTM_IDX_IRQ_STAT   8'h44
`define PTM_IDX_IRQ_MASK   8'h45

// Mode register fields
`define PTM_MODE_AUTO      7
`define PTM_MODE_GATE_HI   6
`define PTM_MODE_GATE_LO   5
`define PTM_MODE_RESTART   4
`define PTM_MODE_PSC_HI    3

// Control register fields
`define PTM_CTRL_START     0
`define PTM_CTRL_STOP      1
`define PTM_CTRL_MULTI     2

// Interrupt status fields
`define PTM_IRQ_EXPIRY     0
`define PTM_IRQ_RELOAD     1

// Reset values
`define PTM_RST_MODE       8'h00
`define PTM_RST_PRESC      8'h00
`define PTM_RST_RELOAD     16'h0000

// Reference 6.78 MHz from 200 MHz pclk: add 678 per cycle, wrap at 20000
`define PTM_REF_KHZ        6780
`define PTM_PCLK_KHZ       200000
`define PTM_ACC_STEP       15'(`PTM_REF_KHZ / 10)
`define PTM_ACC_MOD        15'(`PTM_PCLK_KHZ / 10)

`endif

// file: verilog/ptm_pkg.sv
// Types shared by the protocol timer design.
// Assumes ptm_params.svh for constants; holds types only.
package ptm_pkg;

	typedef enum logic [1:0] {
		PTM_GATE_NONE   = 2'b00,
		PTM_GATE_MOD    = 2'b01,
		PTM_GATE_AUX    = 2'b10,
		PTM_GATE_ANALOG = 2'b11
	} ptm_gate_t;

	typedef struct packed {
		logic      protocol_auto_start;
		ptm_gate_t gate_select;
		logic      auto_reload_on_expiry;
		logic [3:0] prescale_upper_nibble;
	} ptm_mode_t;

	typedef struct packed {
		logic tx_end;
		logic rx_first_bit;
	} ptm_proto_t;

	typedef struct packed {
		logic modulation_input_pin;
		logic first_aux_pin;
		logic third_analog_test_pin;
	} ptm_gate_pins_t;

endpackage : ptm_pkg

// file: verilog/ptm_timer.sv
// Protocol timer: mode, prescaler, 16-bit down counter, APB registers, interrupt.
// Assumes pclk at 200 MHz, protocol pulses on pclk, gate pins asynchronous.
`timescale 1ns/1ps
`include "ptm_params.svh"

module ptm_timer #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [9:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Protocol engine events
	input  wire ptm_pkg::ptm_proto_t     proto,
	// Gate pins
	input  wire ptm_pkg::ptm_gate_pins_t gate_pins,
	// Status out
	output logic                         timer_active_status,
	output logic                         irq
);

	if (CNT_W < 2 || CNT_W > 32) begin : g_chk
		$error("ptm_timer: CNT_W must be 2 to 32");
	end

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		ptm_pkg::ptm_mode_t      mode;
		logic [7:0]              prescale_lower_byte;
		logic [CNT_W-1:0]        reload_value;
		logic                    multi_frame_receive;
		logic [CNT_W-1:0]        count;
		logic                    run;
		logic [11:0]             psc_cnt;
		logic [14:0]             ref_acc;
		logic [1:0]              irq_stat;
		logic [1:0]              irq_mask;
		ptm_pkg::ptm_gate_pins_t gate_s1;
		ptm_pkg::ptm_gate_pins_t gate_s2;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic                    irq;
	} ptm_state_t;

	ptm_state_t st_q;
	ptm_state_t st_d;

	function automatic logic [7:0] addr_idx(input logic [9:0] a);
		addr_idx = a[9:2];
	endfunction : addr_idx

	function automatic logic known_idx(input logic [7:0] i);
		known_idx = (i == `PTM_IDX_MODE) || (i == `PTM_IDX_PRESC) ||
			(i == `PTM_IDX_RELOAD) || (i == `PTM_IDX_COUNT) ||
			(i == `PTM_IDX_CTRL) || (i == `PTM_IDX_STATUS) ||
			(i == `PTM_IDX_IRQ_STAT) || (i == `PTM_IDX_IRQ_MASK);
	endfunction : known_idx

	////////////////////////////////////////////////////////////////////////
	// Next state

	logic [7:0]       idx;
	logic             wr;
	logic             setup;
	logic             ref_en;
	logic [14:0]      acc_sum;
	logic [11:0]      psc_val;
	logic             gate_open;
	logic             tick;
	logic             sw_start;
	logic             sw_stop;
	logic             start_evt;
	logic             stop_evt;
	logic             end_hit;
	logic [1:0]       evt;
	logic [1:0]       w1c;
	logic [31:0]      rd;

	always_comb begin
		st_d    = st_q;
		idx     = addr_idx(paddr);
		setup   = psel && !penable;
		// Write lands at the access edge where pready is sampled high
		wr      = psel && penable && pwrite && st_q.pready && known_idx(idx);

		// Gate pins through two flops
		st_d.gate_s1 = gate_pins;
		st_d.gate_s2 = st_q.gate_s1;

		// Fractional divider: 678/20000 of pclk gives the 6.78 MHz reference
		acc_sum = st_q.ref_acc + `PTM_ACC_STEP;
		ref_en  = acc_sum >= `PTM_ACC_MOD;
		st_d.ref_acc = ref_en ? acc_sum - `PTM_ACC_MOD : acc_sum;

		// Register writes
		sw_start = 1'b0;
		sw_stop  = 1'b0;
		w1c      = 2'b00;
		if (wr) begin
			unique case (idx)
				`PTM_IDX_MODE: begin
					st_d.mode = ptm_pkg::ptm_mode_t'(pwdata[7:0]);
				end
				`PTM_IDX_PRESC: begin
					st_d.prescale_lower_byte = pwdata[7:0];
				end
				`PTM_IDX_RELOAD: begin
					st_d.reload_value = pwdata[CNT_W-1:0];
				end
				`PTM_IDX_CTRL: begin
					sw_start                 = pwdata[`PTM_CTRL_START];
					sw_stop                  = pwdata[`PTM_CTRL_STOP];
					st_d.multi_frame_receive = pwdata[`PTM_CTRL_MULTI];
				end
				`PTM_IDX_IRQ_STAT: begin
					w1c = pwdata[1:0];
				end
				`PTM_IDX_IRQ_MASK: begin
					st_d.irq_mask = pwdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// Prescaler 0 acts as 1 so the divider never stalls
		psc_val = {st_q.mode.prescale_upper_nibble, st_q.prescale_lower_byte};

		unique case (st_q.mode.gate_select)
			ptm_pkg::PTM_GATE_NONE:   gate_open = 1'b1;
			ptm_pkg::PTM_GATE_MOD:    gate_open = st_q.gate_s2.modulation_input_pin;
			ptm_pkg::PTM_GATE_AUX:    gate_open = st_q.gate_s2.first_aux_pin;
			ptm_pkg::PTM_GATE_ANALOG: gate_open = st_q.gate_s2.third_analog_test_pin;
		endcase

		// Protocol events only count with auto-start set
		start_evt = sw_start || (st_q.mode.protocol_auto_start && proto.tx_end);
		stop_evt  = sw_stop
			|| (st_q.mode.protocol_auto_start && !st_q.multi_frame_receive
			&& proto.rx_first_bit);

		evt  = 2'b00;
		tick = 1'b0;
		if (st_q.run && gate_open && ref_en) begin
			if (st_q.psc_cnt + 12'h001 >= psc_val) begin
				tick         = 1'b1;
				st_d.psc_cnt = 12'h000;
			end else begin
				st_d.psc_cnt = st_q.psc_cnt + 12'h001;
			end
		end

		end_hit = st_q.count <= CNT_W'(1);
		if (tick) begin
			if (!end_hit) begin
				st_d.count = st_q.count - CNT_W'(1);
			end else if (st_q.mode.auto_reload_on_expiry) begin
				st_d.count = st_q.reload_value;
				evt[`PTM_IRQ_RELOAD] = 1'b1;
			end else begin
				st_d.count = '0;
				st_d.run   = 1'b0;
				evt[`PTM_IRQ_EXPIRY] = 1'b1;
			end
		end

		// Stop beats a start in the same cycle; a start reloads from the register
		if (stop_evt) begin
			st_d.run = 1'b0;
		end else if (start_evt) begin
			st_d.run     = 1'b1;
			st_d.count   = st_q.reload_value;
			st_d.psc_cnt = 12'h000;
		end

		// A new event wins over its own clear
		st_d.irq_stat = (st_q.irq_stat & ~w1c) | evt;
		st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);

		// Read data captured in setup, shown in access with pready
		rd = 32'h0000_0000;
		unique case (idx)
			`PTM_IDX_MODE:     rd[7:0] = st_q.mode;
			`PTM_IDX_PRESC:    rd[7:0] = st_q.prescale_lower_byte;
			`PTM_IDX_RELOAD:   rd[CNT_W-1:0] = st_q.reload_value;
			`PTM_IDX_COUNT:    rd[CNT_W-1:0] = st_q.count;
			`PTM_IDX_CTRL:     rd[`PTM_CTRL_MULTI] = st_q.multi_frame_receive;
			`PTM_IDX_STATUS:   rd[0] = st_q.run;
			`PTM_IDX_IRQ_STAT: rd[1:0] = st_q.irq_stat;
			`PTM_IDX_IRQ_MASK: rd[1:0] = st_q.irq_mask;
			default:           rd = 32'h0000_0000;
		endcase
		st_d.pready  = setup;
		st_d.pslverr = setup && !known_idx(idx);
		st_d.prdata  = (setup && !pwrite) ? rd : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q                     <= '0;
			st_q.mode                <= ptm_pkg::ptm_mode_t'(`PTM_RST_MODE);
			st_q.prescale_lower_byte <= `PTM_RST_PRESC;
			st_q.reload_value        <= CNT_W'(`PTM_RST_RELOAD);
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata              = st_q.prdata;
	assign pready              = st_q.pready;
	assign pslverr             = st_q.pslverr;
	assign timer_active_status = st_q.run;
	assign irq                 = st_q.irq;

endmodule : ptm_timer
